// ==== hw/dmct_pkg.sv ====
package dmct_pkg;
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_8RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  localparam logic [1:0] DIV_SEL_12 = 2'h0;
  localparam logic [1:0] DIV_SEL_4 = 2'h1;
  localparam logic [1:0] DIV_SEL_48 = 2'h2;
  localparam logic [1:0] DIV_SEL_EXT8 = 2'h3;
  localparam logic [5:0] DIV_12_LAST = 6'h0B;
  localparam logic [5:0] DIV_4_LAST = 6'h03;
  localparam logic [5:0] DIV_48_LAST = 6'h2F;
  localparam logic [2:0] DIV_EXT_LAST = 3'h7;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [12:0] MODE0_ALL_ONES = 13'h1FFF;
  localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
endpackage

// ==== hw/dmct_timers.sv ====
`timescale 1ns/1ps
// Behaviour
// - each timer keeps a 16-bit count written and read as low and high bytes.
// - mode 0 counts 13 bits: high byte eight upper, low byte bits 4..0.
// - mode 0 wrap from 0x1FFF to 0 sets overflow flag and interrupt if enabled.
// - counter select one increments on each falling edge of the count pin.
// - counter select zero counts system clock or prescaled clock per clock select.
// - count only when run and (no gating or gate input at active level); B with A split ignores its run and gate.
// - setting run leaves the count untouched; software loads it first.
// - mode 1 is mode 0 over all 16 bits.
// - mode 2 low byte counts, reloads from high byte on wrap, sets overflow.
// - mode 3 timer A low byte uses timer A controls and sources.
// - mode 3 timer A high byte times internal clock, runs on B run, flags B.
// - with A split, B counts internal only and never sets its flag.
// - with A split, B runs in modes 0 to 2 and stops in mode 3.
// - timer B repeats modes 0 to 2 with its own bytes and bits.
// - each timer has its own two-bit mode field.
// - mode codes 00 13-bit, 01 16-bit, 10 reload, 11 split or inactive.
// - flags writable by software and cleared on interrupt vector acknowledge.
// - prescaler gives clk/12, clk/4, clk/48 or external clock/8 synchronised.
module dmct_timers (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic count_input_pin_a_i,
  input wire logic count_input_pin_b_i,
  input wire logic external_gate_input_a_i,
  input wire logic external_gate_input_b_i,
  input wire logic ext_clk_i,
  input wire logic timer_a_run_i,
  input wire logic timer_b_run_i,
  input wire logic [1:0] timer_a_mode_i,
  input wire logic [1:0] timer_b_mode_i,
  input wire logic timer_a_counter_select_i,
  input wire logic timer_b_counter_select_i,
  input wire logic timer_a_pin_gating_i,
  input wire logic timer_b_pin_gating_i,
  input wire logic gate_a_polarity_i,
  input wire logic gate_b_polarity_i,
  input wire logic timer_a_clock_select_i,
  input wire logic timer_b_clock_select_i,
  input wire logic [1:0] clock_divider_field_i,
  input wire logic timer_a_irq_enable_i,
  input wire logic timer_b_irq_enable_i,
  input wire logic timer_a_low_byte_we_i,
  input wire logic timer_a_high_byte_we_i,
  input wire logic timer_b_low_byte_we_i,
  input wire logic timer_b_high_byte_we_i,
  input wire logic [7:0] wdata_i,
  input wire logic flag_a_we_i,
  input wire logic flag_b_we_i,
  input wire logic flag_wdata_i,
  input wire logic irq_a_ack_i,
  input wire logic irq_b_ack_i,
  output logic [7:0] timer_a_low_byte_o,
  output logic [7:0] timer_a_high_byte_o,
  output logic [7:0] timer_b_low_byte_o,
  output logic [7:0] timer_b_high_byte_o,
  output logic timer_a_overflow_flag_o,
  output logic timer_b_overflow_flag_o,
  output logic irq_a_o,
  output logic irq_b_o,
  output logic timer_b_overflow_pulse_o
);
  logic [1:0] pin_a_sync_r, pin_a_sync_nxt;
  logic [1:0] pin_b_sync_r, pin_b_sync_nxt;
  logic [1:0] gate_a_sync_r, gate_a_sync_nxt;
  logic [1:0] gate_b_sync_r, gate_b_sync_nxt;
  logic [1:0] ext_sync_r, ext_sync_nxt;
  logic pin_a_prev_r, pin_a_prev_nxt;
  logic pin_b_prev_r, pin_b_prev_nxt;
  logic ext_prev_r, ext_prev_nxt;
  logic [5:0] div_cnt_r, div_cnt_nxt;
  logic [2:0] ext_cnt_r, ext_cnt_nxt;
  logic presc_tick_r, presc_tick_nxt;
  logic [15:0] cnt_a_r, cnt_a_nxt;
  logic [15:0] cnt_b_r, cnt_b_nxt;
  logic flag_a_r, flag_a_nxt;
  logic flag_b_r, flag_b_nxt;
  logic ovf_b_pulse_r, ovf_b_pulse_nxt, irq_a_r, irq_a_nxt, irq_b_r, irq_b_nxt;
  logic edge_a, edge_b, ext_edge, split;
  logic gate_ok_a, gate_ok_b, tick_a, tick_b, tick_ah;
  logic ovf_a, ovf_ah, ovf_b;
  logic [5:0] div_last;

  // one timer step for modes 0..2 and the mode 3 low byte; returns ovf in bit 16 above the new count
  function automatic logic [16:0] dmct_step(input logic [1:0] mode, input logic [15:0] cnt);
    logic [16:0] res;
    logic [13:0] s13;
    logic [8:0] s8;
    s13 = {1'b0, cnt[15:8], cnt[4:0]} + 14'h0001;
    s8 = {1'b0, cnt[7:0]} + 9'h001;
    case (mode)
      dmct_pkg::MODE_13BIT: begin
        res = {(cnt[15:8] == dmct_pkg::MODE0_ALL_ONES[12:5]) &&
               (cnt[4:0] == dmct_pkg::MODE0_ALL_ONES[4:0]),
               s13[12:5], cnt[7:5], s13[4:0]};
      end
      dmct_pkg::MODE_16BIT: begin
        res = {1'b0, cnt} + 17'h00001;
      end
      dmct_pkg::MODE_8RELOAD: begin
        res = s8[8] ? {1'b1, cnt[15:8], cnt[15:8]} : {1'b0, cnt[15:8], s8[7:0]};
      end
      default: begin
        res = {(cnt[7:0] == dmct_pkg::BYTE_ALL_ONES), cnt[15:8], s8[7:0]};
      end
    endcase
    return res;
  endfunction
  always_comb begin
    pin_a_sync_nxt = {pin_a_sync_r[0], count_input_pin_a_i};
    pin_b_sync_nxt = {pin_b_sync_r[0], count_input_pin_b_i};
    gate_a_sync_nxt = {gate_a_sync_r[0], external_gate_input_a_i};
    gate_b_sync_nxt = {gate_b_sync_r[0], external_gate_input_b_i};
    ext_sync_nxt = {ext_sync_r[0], ext_clk_i};
    pin_a_prev_nxt = pin_a_sync_r[1];
    pin_b_prev_nxt = pin_b_sync_r[1];
    ext_prev_nxt = ext_sync_r[1];
  end

  assign edge_a = pin_a_prev_r & ~pin_a_sync_r[1];
  assign edge_b = pin_b_prev_r & ~pin_b_sync_r[1];
  assign ext_edge = ~ext_prev_r & ext_sync_r[1];

  always_comb begin
    case (clock_divider_field_i)
      dmct_pkg::DIV_SEL_4: div_last = dmct_pkg::DIV_4_LAST;
      dmct_pkg::DIV_SEL_48: div_last = dmct_pkg::DIV_48_LAST;
      default: div_last = dmct_pkg::DIV_12_LAST;
    endcase
    div_cnt_nxt = div_cnt_r;
    ext_cnt_nxt = ext_cnt_r;
    presc_tick_nxt = 1'b0;
    if (clock_divider_field_i == dmct_pkg::DIV_SEL_EXT8) begin
      if (ext_edge) begin
        ext_cnt_nxt = ext_cnt_r + 3'h1;
        presc_tick_nxt = (ext_cnt_r == dmct_pkg::DIV_EXT_LAST);
      end
    end else if (div_cnt_r >= div_last) begin
      div_cnt_nxt = 6'h00;
      presc_tick_nxt = 1'b1;
    end else begin
      div_cnt_nxt = div_cnt_r + 6'h01;
    end
  end

  assign split = (timer_a_mode_i == dmct_pkg::MODE_SPLIT);
  assign gate_ok_a = ~timer_a_pin_gating_i | (gate_a_sync_r[1] == gate_a_polarity_i);
  assign gate_ok_b = ~timer_b_pin_gating_i | (gate_b_sync_r[1] == gate_b_polarity_i);

  always_comb begin
    tick_a = timer_a_run_i & gate_ok_a &
             (timer_a_counter_select_i ? edge_a :
              (timer_a_clock_select_i | presc_tick_r));
    tick_ah = split & timer_b_run_i &
              (timer_a_clock_select_i | presc_tick_r);
    if (split) begin
      tick_b = (timer_b_mode_i != dmct_pkg::MODE_SPLIT) &
               (timer_b_clock_select_i | presc_tick_r);
    end else begin
      tick_b = timer_b_run_i & gate_ok_b & (timer_b_mode_i != dmct_pkg::MODE_SPLIT) &
               (timer_b_counter_select_i ? edge_b :
                (timer_b_clock_select_i | presc_tick_r));
    end
  end

  always_comb begin
    logic [16:0] sa;
    logic [16:0] sb;
    sa = dmct_step(timer_a_mode_i, cnt_a_r);
    sb = dmct_step(timer_b_mode_i, cnt_b_r);
    cnt_a_nxt = cnt_a_r;
    cnt_b_nxt = cnt_b_r;
    ovf_a = 1'b0;
    ovf_ah = 1'b0;
    ovf_b = 1'b0;
    if (tick_a) begin
      cnt_a_nxt[7:0] = sa[7:0];
      if (!split) begin
        cnt_a_nxt[15:8] = sa[15:8];
      end
      ovf_a = sa[16];
    end
    if (tick_ah) begin
      {ovf_ah, cnt_a_nxt[15:8]} = {1'b0, cnt_a_r[15:8]} + 9'h001;
    end
    if (tick_b) begin
      cnt_b_nxt = sb[15:0];
      ovf_b = sb[16];
    end
    if (timer_a_low_byte_we_i) begin
      cnt_a_nxt[7:0] = wdata_i;
    end
    if (timer_a_high_byte_we_i) begin
      cnt_a_nxt[15:8] = wdata_i;
    end
    if (timer_b_low_byte_we_i) begin
      cnt_b_nxt[7:0] = wdata_i;
    end
    if (timer_b_high_byte_we_i) begin
      cnt_b_nxt[15:8] = wdata_i;
    end
    flag_a_nxt = flag_a_r;
    if (flag_a_we_i) begin
      flag_a_nxt = flag_wdata_i;
    end else if (irq_a_ack_i) begin
      flag_a_nxt = 1'b0;
    end
    if (ovf_a) begin
      flag_a_nxt = 1'b1;
    end
    flag_b_nxt = flag_b_r;
    if (flag_b_we_i) begin
      flag_b_nxt = flag_wdata_i;
    end else if (irq_b_ack_i) begin
      flag_b_nxt = 1'b0;
    end
    if (split ? ovf_ah : ovf_b) begin
      flag_b_nxt = 1'b1;
    end
    ovf_b_pulse_nxt = ovf_b;
    irq_a_nxt = flag_a_nxt & timer_a_irq_enable_i;
    irq_b_nxt = flag_b_nxt & timer_b_irq_enable_i;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_a_sync_r <= 2'h3;
      pin_b_sync_r <= 2'h3;
      gate_a_sync_r <= 2'h0;
      gate_b_sync_r <= 2'h0;
      ext_sync_r <= 2'h0;
      pin_a_prev_r <= 1'b1;
      pin_b_prev_r <= 1'b1;
      ext_prev_r <= 1'b0;
      div_cnt_r <= 6'h00;
      ext_cnt_r <= 3'h0;
      presc_tick_r <= 1'b0;
      cnt_a_r <= dmct_pkg::COUNT_RESET;
      cnt_b_r <= dmct_pkg::COUNT_RESET;
      flag_a_r <= 1'b0;
      flag_b_r <= 1'b0;
      ovf_b_pulse_r <= 1'b0;
      irq_a_r <= 1'b0;
      irq_b_r <= 1'b0;
    end else begin
      pin_a_sync_r <= pin_a_sync_nxt;
      pin_b_sync_r <= pin_b_sync_nxt;
      gate_a_sync_r <= gate_a_sync_nxt;
      gate_b_sync_r <= gate_b_sync_nxt;
      ext_sync_r <= ext_sync_nxt;
      pin_a_prev_r <= pin_a_prev_nxt;
      pin_b_prev_r <= pin_b_prev_nxt;
      ext_prev_r <= ext_prev_nxt;
      div_cnt_r <= div_cnt_nxt;
      ext_cnt_r <= ext_cnt_nxt;
      presc_tick_r <= presc_tick_nxt;
      cnt_a_r <= cnt_a_nxt;
      cnt_b_r <= cnt_b_nxt;
      flag_a_r <= flag_a_nxt;
      flag_b_r <= flag_b_nxt;
      ovf_b_pulse_r <= ovf_b_pulse_nxt;
      irq_a_r <= irq_a_nxt;
      irq_b_r <= irq_b_nxt;
    end
  end
  assign timer_a_low_byte_o = cnt_a_r[7:0];
  assign timer_a_high_byte_o = cnt_a_r[15:8];
  assign timer_b_low_byte_o = cnt_b_r[7:0];
  assign timer_b_high_byte_o = cnt_b_r[15:8];
  assign timer_a_overflow_flag_o = flag_a_r;
  assign timer_b_overflow_flag_o = flag_b_r;
  assign irq_a_o = irq_a_r;
  assign irq_b_o = irq_b_r;
  assign timer_b_overflow_pulse_o = ovf_b_pulse_r;
endmodule // dmct_timers

// ==== testbench/dmct_pin_model.sv ====
`timescale 1ns/1ps
module dmct_pin_model (
  input wire logic clk_i,
  input wire logic fire_i,
  input wire logic slow_i,
  output logic pin_o
);
  logic [2:0] hold_r = 3'h0;
  // levels held two clocks or more
  always @(posedge clk_i) begin
    if (hold_r != 3'h0) begin
      hold_r <= hold_r - 3'h1;
    end else if (fire_i) begin
      hold_r <= slow_i ? 3'h7 : 3'h5;
    end
  end
  assign pin_o = hold_r < 3'h3;
endmodule // dmct_pin_model

// ==== testbench/dmct_timers_checker.sv ====
`timescale 1ns/1ps
module dmct_timers_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic timer_a_run_i,
  input wire logic timer_b_run_i,
  input wire logic [1:0] timer_a_mode_i,
  input wire logic timer_a_counter_select_i,
  input wire logic timer_a_pin_gating_i,
  input wire logic timer_a_clock_select_i,
  input wire logic timer_a_irq_enable_i,
  input wire logic timer_a_low_byte_we_i,
  input wire logic timer_a_high_byte_we_i,
  input wire logic [7:0] wdata_i,
  input wire logic flag_a_we_i,
  input wire logic flag_b_we_i,
  input wire logic flag_wdata_i,
  input wire logic irq_a_ack_i,
  input wire logic [7:0] timer_a_low_byte_o,
  input wire logic [7:0] timer_a_high_byte_o,
  input wire logic timer_a_overflow_flag_o,
  input wire logic timer_b_overflow_flag_o,
  input wire logic irq_a_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [15:0] cnt;
  logic idle;
  assign cnt = {timer_a_high_byte_o, timer_a_low_byte_o};
  assign idle = !timer_a_low_byte_we_i && !timer_a_high_byte_we_i;
  sequence a_sys_run;
    (timer_a_run_i && timer_a_clock_select_i && !timer_a_counter_select_i
      && !timer_a_pin_gating_i && timer_a_mode_i != dmct_pkg::MODE_SPLIT) [*3];
  endsequence
  sequence a_stopped;
    (!timer_a_run_i) [*4];
  endsequence
  chk_mode1_step: assert property (
    a_sys_run ##0 idle && timer_a_mode_i == dmct_pkg::MODE_16BIT
      |=> cnt == $past(cnt) + 16'h0001) else $error("mode 1 step wrong");
  chk_mode0_wrap: assert property (
    a_sys_run ##0 idle && timer_a_mode_i == dmct_pkg::MODE_13BIT
      && {timer_a_high_byte_o, timer_a_low_byte_o[4:0]} == dmct_pkg::MODE0_ALL_ONES
      |=> {timer_a_high_byte_o, timer_a_low_byte_o[4:0]} == 13'h0000 && timer_a_overflow_flag_o)
    else $error("mode 0 wrap wrong");
  chk_mode2_reload: assert property (
    a_sys_run ##0 idle && timer_a_mode_i == dmct_pkg::MODE_8RELOAD
      && timer_a_low_byte_o == dmct_pkg::BYTE_ALL_ONES
      |=> timer_a_low_byte_o == $past(timer_a_high_byte_o) && $stable(timer_a_high_byte_o)
      && timer_a_overflow_flag_o) else $error("reload wrong");
  chk_stopped_hold: assert property (
    a_stopped ##0 idle && timer_a_mode_i != dmct_pkg::MODE_SPLIT |=> $stable(cnt))
    else $error("stopped count moved");
  chk_ack_clear: assert property (
    a_stopped ##0 irq_a_ack_i && !flag_a_we_i |=> !timer_a_overflow_flag_o)
    else $error("ack left flag set");
  chk_flag_write: assert property (
    (!timer_b_run_i) [*4] ##0 flag_b_we_i |=> timer_b_overflow_flag_o == $past(flag_wdata_i))
    else $error("flag write lost");
  chk_low_write: assert property (
    timer_a_low_byte_we_i |=> timer_a_low_byte_o == $past(wdata_i)) else $error("byte write lost");
  chk_irq_a_gate: assert property (
    irq_a_o == (timer_a_overflow_flag_o && $past(timer_a_irq_enable_i)))
    else $error("irq wrong");
endmodule // dmct_timers_checker

// ==== testbench/dmct_timers_test.sv ====
`timescale 1ns/1ps
module dmct_timers_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic count_input_pin_a_i, count_input_pin_b_i, external_gate_input_a_i, timer_a_run_i;
  logic external_gate_input_b_i, ext_clk_i, timer_b_run_i, fire_a, slow, flag_wdata_i;
  logic [1:0] timer_a_mode_i, timer_b_mode_i, clock_divider_field_i;
  logic timer_a_counter_select_i, timer_b_counter_select_i, timer_a_pin_gating_i;
  logic timer_b_pin_gating_i, gate_a_polarity_i, gate_b_polarity_i, timer_a_clock_select_i;
  logic timer_b_clock_select_i, timer_a_irq_enable_i, timer_b_irq_enable_i;
  logic timer_a_low_byte_we_i, timer_a_high_byte_we_i, timer_b_low_byte_we_i;
  logic timer_b_high_byte_we_i, flag_a_we_i, flag_b_we_i, irq_a_ack_i, irq_b_ack_i;
  logic [7:0] wdata_i, timer_a_low_byte_o, timer_a_high_byte_o, timer_b_low_byte_o;
  logic [7:0] timer_b_high_byte_o;
  logic timer_a_overflow_flag_o, timer_b_overflow_flag_o, irq_a_o, irq_b_o;
  logic timer_b_overflow_pulse_o;
  logic [16:0] e;
  logic [15:0] v;
  logic [1:0] m;
  integer seed = 32'h10B4;
  int failures = 0;
  int checked = 0;
  int n;
  int pulses = 0;
  wire [15:0] cnt_a = {timer_a_high_byte_o, timer_a_low_byte_o};
  wire [15:0] cnt_b = {timer_b_high_byte_o, timer_b_low_byte_o};
  always #5 clk_i = ~clk_i;
  always @(negedge clk_i) begin
    pulses <= pulses + int'(timer_b_overflow_pulse_o);
  end
  dmct_timers uut (.*);
  dmct_pin_model pin_a (.clk_i(clk_i), .fire_i(fire_a), .slow_i(slow), .pin_o(count_input_pin_a_i));
  dmct_pin_model pin_b (.clk_i(clk_i), .fire_i(fire_a), .slow_i(slow), .pin_o(count_input_pin_b_i));
  function automatic logic [16:0] predict(input logic [1:0] md, input logic [15:0] c, input int k);
    logic f;
    logic [12:0] t;
    f = 1'b0;
    repeat (k) begin
      t = {c[15:8], c[4:0]} + 13'h0001;
      if (md == dmct_pkg::MODE_13BIT) begin
        c = {t[12:5], c[7:5], t[4:0]};
        f = f | (t == 13'h0000);
      end else if (md == dmct_pkg::MODE_16BIT) begin
        c = c + 16'h0001;
        f = f | (c == 16'h0000);
      end else begin
        f = f | (c[7:0] == 8'hFF);
        c[7:0] = (c[7:0] == 8'hFF) ? c[15:8] : c[7:0] + 8'h01;
      end
    end
    return {f, c};
  endfunction
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task load(input logic [15:0] val, input logic b);
    @(negedge clk_i);
    wdata_i = val[7:0];
    {timer_b_low_byte_we_i, timer_a_low_byte_we_i} = {b, !b};
    @(negedge clk_i);
    {timer_b_low_byte_we_i, timer_a_low_byte_we_i} = 2'h0;
    wdata_i = val[15:8];
    {timer_b_high_byte_we_i, timer_a_high_byte_we_i} = {b, !b};
    @(negedge clk_i);
    {timer_b_high_byte_we_i, timer_a_high_byte_we_i} = 2'h0;
  endtask
  task run(input logic [1:0] r, input int k);
    {timer_b_run_i, timer_a_run_i} = r;
    repeat (k) @(negedge clk_i);
    {timer_b_run_i, timer_a_run_i} = 2'h0;
    repeat (6) @(negedge clk_i);
  endtask
  task fire(input int k);
    repeat (k) begin
      fire_a = 1'b1;
      slow = 1'($random(seed));
      @(negedge clk_i);
      fire_a = 1'b0;
      repeat (11) @(negedge clk_i);
    end
  endtask
  task final_report;
    if (failures == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    {timer_a_run_i, timer_b_run_i, timer_a_mode_i, timer_b_mode_i, clock_divider_field_i,
      ext_clk_i, external_gate_input_a_i, external_gate_input_b_i, timer_a_counter_select_i,
      timer_b_counter_select_i, timer_a_pin_gating_i, timer_b_pin_gating_i, gate_a_polarity_i,
      gate_b_polarity_i, timer_a_clock_select_i, timer_b_clock_select_i, timer_a_irq_enable_i,
      timer_b_irq_enable_i, timer_a_low_byte_we_i, timer_a_high_byte_we_i, timer_b_low_byte_we_i,
      timer_b_high_byte_we_i, wdata_i, flag_a_we_i, flag_b_we_i, flag_wdata_i, irq_a_ack_i,
      irq_b_ack_i, fire_a, slow} = '0;
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    chk(cnt_a, 16'h0000);
    {flag_wdata_i, flag_a_we_i, timer_a_irq_enable_i} = 3'h7;
    @(negedge clk_i);
    flag_a_we_i = 1'b0;
    chk({15'h0, irq_a_o}, 16'h0001);
    timer_a_clock_select_i = 1'b1;
    for (int i = 0; i < 3; i++) begin
      m = i[1:0];
      n = 8 + ($random(seed) & 15);
      v = 16'($random(seed));
      v = v | (m == 2'h0 ? 16'hFF1C : m == 2'h1 ? 16'hFFF0 : 16'h00F8);
      timer_a_mode_i = m;
      timer_a_irq_enable_i = 1'($random(seed));
      irq_a_ack_i = 1'b1;
      load(v, 1'b0);
      irq_a_ack_i = 1'b0;
      chk({15'h0, timer_a_overflow_flag_o}, 16'h0000);
      run(2'h1, n);
      e = predict(m, v, n);
      v = (m == 2'h0) ? 16'hFF1F : 16'hFFFF;
      chk(cnt_a & v, e[15:0] & v);
      chk({irq_a_o, timer_a_overflow_flag_o}, {e[16] & timer_a_irq_enable_i, e[16]});
    end
    {timer_a_mode_i, timer_a_counter_select_i, timer_a_pin_gating_i} = 4'h7;
    gate_a_polarity_i = 1'($random(seed));
    external_gate_input_a_i = !gate_a_polarity_i;
    v = 16'($random(seed));
    load(v, 1'b0);
    timer_a_run_i = 1'b1;
    fire(2);
    chk(cnt_a, v);
    external_gate_input_a_i = gate_a_polarity_i;
    n = 1 + ($random(seed) & 7);
    fire(n);
    timer_a_run_i = 1'b0;
    v = v + n[15:0];
    chk(cnt_a, v);
    {timer_a_counter_select_i, timer_a_pin_gating_i, timer_a_clock_select_i} = 3'h0;
    for (int d = 0; d < 4; d++) begin
      clock_divider_field_i = d[1:0];
      repeat (50) @(negedge clk_i);
      if (d == 3) begin
        timer_a_run_i = 1'b1;
        for (int t = 0; t < 32; t++) begin
          ext_clk_i = t[0];
          repeat (2) @(negedge clk_i);
        end
      end
      run(2'h1, d == 0 ? 24 : d == 1 ? 8 : d == 2 ? 96 : 6);
      v = v + 16'h0002;
      chk(cnt_a, v);
    end
    timer_b_mode_i = dmct_pkg::MODE_SPLIT;
    timer_a_mode_i = dmct_pkg::MODE_SPLIT;
    {timer_a_clock_select_i, timer_b_clock_select_i, timer_b_counter_select_i} = 3'h7;
    {timer_b_pin_gating_i, timer_b_irq_enable_i, flag_wdata_i} = 3'h6;
    load({8'hFE, v[7:0]}, 1'b0);
    load(16'h0000, 1'b1);
    flag_b_we_i = 1'b1;
    @(negedge clk_i);
    flag_b_we_i = 1'b0;
    {timer_b_run_i, timer_b_mode_i} = 3'h5;
    repeat (3) @(negedge clk_i);
    {timer_b_run_i, timer_b_mode_i} = 3'h3;
    repeat (6) @(negedge clk_i);
    chk(cnt_a, {8'h01, v[7:0]});
    chk({irq_b_o, timer_b_overflow_flag_o}, 16'h0003);
    chk(cnt_b, 16'h0003);
    run(2'h2, 3);
    chk(cnt_b, 16'h0003);
    chk(cnt_a, {8'h04, v[7:0]});
    flag_b_we_i = 1'b1;
    load(16'hFFFE, 1'b1);
    flag_b_we_i = 1'b0;
    n = pulses;
    timer_b_mode_i = dmct_pkg::MODE_16BIT;
    repeat (4) @(negedge clk_i);
    timer_b_mode_i = dmct_pkg::MODE_SPLIT;
    repeat (3) @(negedge clk_i);
    chk(cnt_b, 16'h0002);
    chk({15'h0, timer_b_overflow_flag_o}, 16'h0000);
    chk(16'(pulses - n), 16'h0001);
    final_report;
  end
endmodule // dmct_timers_test
bind dmct_timers dmct_timers_checker chk (.*);
